// File: hw/fcil_loader.sv
// Configuration loader with per-frame CRC check and brown-out handling
// How it works
// - Serial data taken bit 0 first, bit 63 last, then check value bit 0 first, bit 15 last
// - CRC computed per frame, compared with stream value
// - CRC mismatch halts and holds error low
// - Brown-out halts, holds error, blocks user mode
// - Active scheme restarts when supply returns
// - Error low pulse drives memory output enable low
// - Initialization ends within 136 cycles, then user mode
// - Active serial data sampled on own clock rise
`timescale 1ns/1ps
module fcil_loader
  import fcil_pkg::*;
(
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Link clock from host (passive scheme)
  input  wire logic cfg_serial_clock_in,
  // Link pins
  input  wire logic cfg_data_in,
  output logic      cfg_serial_clock_out,
  output logic      cfg_serial_clock_oe_n,
  // Status and control pins
  input  wire logic scheme_active,
  input  wire logic cfg_request_n,
  input  wire logic supply_ok,
  output logic      cfg_error_n_out,
  output logic      cfg_error_oe_n,
  output logic      mem_oe_n,
  output logic      cfg_complete_line_out,
  output logic      cfg_complete_line_oe_n,
  output logic      user_mode
);

  // Link clock: own divider in active scheme, host pin in passive scheme
  logic       lclk_div_r;     // Divided clock toward memory
  logic [7:0] div_cnt_r;      // Divider count
  logic [1:0] act_sync_r;     // Scheme strap synchroniser
  logic       link_clk;       // Clock used by the link logic
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_r  <= 8'h00;
      lclk_div_r <= 1'b0;
    end else if (div_cnt_r == 8'(LINK_DIV - 1)) begin
      div_cnt_r  <= 8'h00;
      lclk_div_r <= ~lclk_div_r;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  // Mux is a hazard only during a scheme change, which needs a reset anyway
  // Active scheme clocks on the pin copy, so data is taken on the edge the memory sees
  assign link_clk = act_sync_r[1] ? cfg_serial_clock_out : cfg_serial_clock_in;

  // Level from core to link: load enable, cleared at once, released after two link edges
  // Host clock runs only inside bursts, so a plain two-flop copy would keep a stale
  // enable across an error and the next burst would start mid-frame
  logic load_en_r;            // Core side: loading allowed
  logic en_rst_n;             // Link enable clear, low outside loading
  logic en_s1_r, en_s2_r;     // Link side synchroniser
  logic [1:0] rst_sync_r;     // Supply good synchroniser
  assign en_rst_n = resetn & load_en_r;
  always_ff @(posedge link_clk or negedge en_rst_n) begin
    if (!en_rst_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else begin
      en_s1_r <= 1'b1;
      en_s2_r <= en_s1_r;
    end
  end

  // Link side shifter and CRC, rising edge of link clock
  logic [7:0]          bit_cnt_r;    // Bit position within frame + CRC
  logic [15:0]         crc_r;        // Running CRC
  logic [15:0]         recv_r;       // Received check value
  fcil_frame_type      frame_r;      // Held frame result
  logic                frame_tgl_r;  // Toggles on each finished frame
  localparam logic [7:0] LAST_BIT = 8'(FRAME_BITS + CRC_BITS - 1);
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r   <= 8'h00;
      crc_r       <= CRC_SEED;
      recv_r      <= 16'h0000;
      frame_r     <= '0;
      frame_tgl_r <= 1'b0;
    end else if (!en_s2_r) begin
      // Partial frame thrown away on halt
      bit_cnt_r <= 8'h00;
      crc_r     <= CRC_SEED;
    end else begin
      // One bit per clock, serial order is LSB first
      if (bit_cnt_r < 8'(FRAME_BITS)) begin
        crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ cfg_data_in) ? CRC_POLY : 16'h0000);
      end else begin
        recv_r <= {cfg_data_in, recv_r[15:1]};
      end
      if (bit_cnt_r == LAST_BIT) begin
        bit_cnt_r           <= 8'h00;
        crc_r               <= CRC_SEED;
        frame_r.crc_calc    <= crc_r;
        frame_r.crc_recv    <= {cfg_data_in, recv_r[15:1]};
        frame_tgl_r         <= ~frame_tgl_r;
      end else begin
        bit_cnt_r <= bit_cnt_r + 8'h01;
      end
    end
  end

  // Frame event into core domain by toggle; frame word stable once toggled
  logic [2:0] tgl_sync_r;     // Toggle synchroniser plus edge history
  logic       frame_evt;      // One core cycle per finished frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) tgl_sync_r <= 3'b000;
    else         tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
  end
  assign frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];

  // Pin inputs synchronised to core clock
  always_ff @(posedge core_clk or negedge resetn) begin
    // Supply taken as good at release, so reset itself never looks like a brown-out
    if (!resetn) rst_sync_r <= 2'b11;
    else         rst_sync_r <= {rst_sync_r[0], supply_ok};
  end
  logic [1:0] req_sync_r;     // Config request synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      req_sync_r <= 2'b11;
      act_sync_r <= 2'b00;
    end else begin
      req_sync_r <= {req_sync_r[0], cfg_request_n};
      act_sync_r <= {act_sync_r[0], scheme_active};
    end
  end
  logic supply_good, req_low, is_active;
  assign supply_good = rst_sync_r[1];
  assign req_low     = ~req_sync_r[1];
  assign is_active   = act_sync_r[1];

  // Core state machine
  typedef enum logic [2:0] {ST_LOAD, ST_INIT, ST_USER, ST_ERROR, ST_WAIT} fcil_state_type;
  fcil_state_type state_r;    // Current state
  logic [7:0]     frame_cnt_r;  // Frames accepted so far
  logic [7:0]     cnt_r;        // Init or error pulse counter
  logic           req_seen_r;   // Host restart request seen during error
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= ST_LOAD;
      frame_cnt_r <= 8'h00;
      cnt_r       <= 8'h00;
      req_seen_r  <= 1'b0;
    end else if (!supply_good && state_r != ST_ERROR && state_r != ST_WAIT) begin
      // Brown-out beats everything
      state_r <= ST_ERROR;
      cnt_r   <= 8'h00;
    end else begin
      unique case (state_r)
        ST_LOAD: begin
          if (req_low) begin
            frame_cnt_r <= 8'h00;  // Host restart mid-load
          end else if (frame_evt) begin
            if (frame_r.crc_calc != frame_r.crc_recv) begin
              state_r <= ST_ERROR;
              cnt_r   <= 8'h00;
            end else if (frame_cnt_r == 8'(FRAME_COUNT - 1)) begin
              state_r <= ST_INIT;
              cnt_r   <= 8'h00;
            end else begin
              frame_cnt_r <= frame_cnt_r + 8'h01;
            end
          end
        end
        ST_INIT: begin
          // Finish after INIT_CYCLES cycles, right at the limit
          if (cnt_r == 8'(INIT_CYCLES - 1)) state_r <= ST_USER;
          else cnt_r <= cnt_r + 8'h01;
        end
        ST_USER: begin
          if (req_low) begin
            state_r     <= ST_LOAD;
            frame_cnt_r <= 8'h00;
          end
        end
        ST_ERROR: begin
          // Hold error while pulse runs or supply is bad
          frame_cnt_r <= 8'h00;
          if (cnt_r != 8'(ERR_PULSE_CYCLES - 1)) cnt_r <= cnt_r + 8'h01;
          else if (supply_good) state_r <= ST_WAIT;
          req_seen_r <= 1'b0;
        end
        ST_WAIT: begin
          // Error held; active with request idle restarts alone
          // Passive only restarts on a host request pulse
          if (!supply_good) begin
            state_r <= ST_ERROR;
            cnt_r   <= 8'h00;
          end else if (is_active && !req_low) begin
            state_r <= ST_LOAD;
          end else if (req_low) begin
            req_seen_r <= 1'b1;
          end else if (req_seen_r) begin
            state_r    <= ST_LOAD;
            req_seen_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Loading enabled only in load state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) load_en_r <= 1'b0;
    else         load_en_r <= (state_r == ST_LOAD);
  end

  // Pin outputs, all registered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_error_n_out        <= 1'b0;
      cfg_error_oe_n         <= 1'b1;
      mem_oe_n               <= 1'b0;
      cfg_complete_line_out  <= 1'b0;
      cfg_complete_line_oe_n <= 1'b0;
      user_mode              <= 1'b0;
      cfg_serial_clock_out   <= 1'b0;
      cfg_serial_clock_oe_n  <= 1'b1;
    end else begin
      cfg_error_n_out        <= 1'b0;
      cfg_error_oe_n         <= !(state_r == ST_ERROR || state_r == ST_WAIT);
      // Memory held in reset while the error line is pulled low
      mem_oe_n               <= !(state_r == ST_ERROR || state_r == ST_WAIT);
      cfg_complete_line_out  <= 1'b0;
      cfg_complete_line_oe_n <= (state_r == ST_INIT || state_r == ST_USER);
      user_mode              <= (state_r == ST_USER);
      cfg_serial_clock_out   <= lclk_div_r;
      cfg_serial_clock_oe_n  <= !(is_active && state_r == ST_LOAD);
    end
  end

endmodule

// File: hw/fcil_pkg.sv
// Package: constants and types for the configuration integrity loader
package fcil_pkg;

  localparam int unsigned CORE_CLK_MHZ     = 250;   // Core clock rate
  localparam int unsigned INIT_CYCLES      = 136;   // Initialization length after done
  localparam int unsigned FRAME_BITS       = 64;    // Data bits per frame
  localparam int unsigned CRC_BITS         = 16;    // Check value width
  localparam int unsigned FRAME_COUNT      = 4;     // Frames in one bitstream
  localparam int unsigned ERR_PULSE_CYCLES = 16;    // Error low pulse before retry (active)
  localparam int unsigned LINK_DIV         = 4;     // Core cycles per half link clock
  localparam logic [15:0] CRC_POLY         = 16'h1021; // CRC polynomial
  localparam logic [15:0] CRC_SEED         = 16'hffff; // CRC start value

  // Frame word handed from link domain to core domain
  typedef struct packed {
    logic [CRC_BITS-1:0] crc_calc;  // CRC computed on the data
    logic [CRC_BITS-1:0] crc_recv;  // Check value from the stream
  } fcil_frame_type;

  // Scheme select
  typedef enum logic {
    FCIL_PASSIVE = 1'b0,
    FCIL_ACTIVE  = 1'b1
  } fcil_scheme_type;

endpackage

// File: verification/fcil_host_model.sv
// Host model: passive serial source of framed bitstream
`timescale 1ns/1ps
module fcil_host_model
  import fcil_pkg::*;
(
  // Link pins toward the loader
  output logic lk_clk,
  output logic lk_data
);
  initial begin
    lk_clk  = 1'b0;
    lk_data = 1'b0;
  end
  // Clock runs only inside bursts; data inverted once released
  task automatic shift(input logic [79:0] b, input int n);
    #5.3;
    for (int i = 0; i < n; i++) begin
      lk_data = b[i];
      #16 lk_clk = 1'b1;
      #16 lk_clk = 1'b0;
    end
    lk_data = ~lk_data;
  endtask
  // Frame: data then check value, bit 0 first; bad flips one bit
  task automatic frame(input logic [63:0] d, input logic bad);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 0; i < 64; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    shift({c ^ {15'h0000, bad}, d}, 80);
  endtask
endmodule

// File: verification/fcil_loader_checker.sv
// Checker: port-level properties of the configuration loader
`timescale 1ns/1ps
module fcil_loader_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Straps and requests
  input wire logic scheme_active,
  input wire logic cfg_request_n,
  input wire logic supply_ok,
  // Watched outputs
  input wire logic cfg_error_oe_n,
  input wire logic mem_oe_n,
  input wire logic cfg_complete_line_oe_n,
  input wire logic cfg_serial_clock_oe_n,
  input wire logic user_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] req_hi_r;  // Cycles the restart request stayed high
  // Saturating count, so a long-idle request is easy to spot
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) req_hi_r <= 4'h0;
    else if (!cfg_request_n) req_hi_r <= 4'h0;
    else if (req_hi_r != 4'hf) req_hi_r <= req_hi_r + 4'h1;
  end
  a_brown_out_halt: assert property (
    $fell(supply_ok) |-> ##[1:6] (!cfg_error_oe_n && !user_mode))
    else $error("brown-out did not halt");
  a_no_user_err: assert property (
    !cfg_error_oe_n && !$past(cfg_error_oe_n, 2) |-> !user_mode)
    else $error("user mode during error");
  a_init_bound: assert property (
    $rose(cfg_complete_line_oe_n) && supply_ok |-> ##[1:136] user_mode)
    else $error("initialization too long");
  a_user_done_rel: assert property (
    user_mode |-> cfg_complete_line_oe_n)
    else $error("user mode before done");
  a_err_mem_reset: assert property (
    !cfg_error_oe_n && !$past(cfg_error_oe_n) |-> !mem_oe_n)
    else $error("memory enable not low on error");
  a_passive_wait: assert property (
    !scheme_active && !cfg_error_oe_n && req_hi_r == 4'hf |=> !cfg_error_oe_n)
    else $error("passive restart on its own");
  a_active_restart: assert property (
    scheme_active && cfg_request_n && $rose(supply_ok) |-> ##[1:40] cfg_error_oe_n)
    else $error("active scheme did not restart");
  a_passive_clk_off: assert property (
    !scheme_active |-> cfg_serial_clock_oe_n)
    else $error("clock driven in passive scheme");
endmodule
bind fcil_loader fcil_loader_checker u_chk (.core_clk, .resetn, .scheme_active,
  .cfg_request_n, .supply_ok, .cfg_error_oe_n, .mem_oe_n, .cfg_complete_line_oe_n,
  .cfg_serial_clock_oe_n, .user_mode);

// File: verification/testbench.sv
// Testbench: load, corrupt, brown-out and restart scenarios
`timescale 1ns/1ps
module testbench;
  import fcil_pkg::*;
  logic core_clk, resetn, scheme_active, cfg_request_n, supply_ok;
  logic lk_clk, lk_data, clk_out, clk_oe_n, err_out, err_oe_n;
  logic mem_oe_n, done_out, done_oe_n, user_mode;
  int   num_errors, cmp_count, seed;
  always #2 core_clk = ~core_clk;
  fcil_host_model u_host (.lk_clk(lk_clk), .lk_data(lk_data));
  fcil_loader DUT (.core_clk(core_clk), .resetn(resetn), .cfg_serial_clock_in(lk_clk),
    .cfg_data_in(lk_data), .cfg_serial_clock_out(clk_out), .cfg_serial_clock_oe_n(clk_oe_n),
    .scheme_active(scheme_active), .cfg_request_n(cfg_request_n), .supply_ok(supply_ok),
    .cfg_error_n_out(err_out), .cfg_error_oe_n(err_oe_n), .mem_oe_n(mem_oe_n),
    .cfg_complete_line_out(done_out), .cfg_complete_line_oe_n(done_oe_n),
    .user_mode(user_mode));
  task automatic summarize;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Count link clock changes over a fixed core window
  task automatic chk_edges(input int exp);
    int   n;     // Changes seen
    logic prev;  // Last sampled level
    n = 0;
    #1 prev = clk_out;
    repeat (16 * LINK_DIV) begin
      @(posedge core_clk);
      #1;
      if (clk_out !== prev) n++;
      prev = clk_out;
    end
    cmp_count++;
    if (n != exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, exp);
    end
  endtask
  // Expected outcome from the frame flags: any bad frame spoils the load
  task automatic load(input int bad);
    int   bad_q[$];  // Corruption flag of each frame, in send order
    logic exp_ok;    // Load expected to reach user mode
    // Two link edges pass the load enable before the first data bit
    u_host.shift(80'h0, 2);
    for (int i = 0; i < FRAME_COUNT; i++) begin
      bad_q.push_back(int'(i == bad));
      u_host.frame({$random(seed), $random(seed)}, i == bad);
    end
    exp_ok = 1'b1;
    foreach (bad_q[k]) begin
      if (bad_q[k] != 0) exp_ok = 1'b0;
    end
    wait_clk(200);
    chk(user_mode, exp_ok);
    chk(err_oe_n, exp_ok);
    chk(done_oe_n, exp_ok);
    chk(done_out, 1'b0);
    chk(mem_oe_n, exp_ok);
    $display("load test bad=%0d done", bad);
  endtask
  // Host restart: request low, then high
  task automatic restart;
    cfg_request_n <= 1'b0;
    wait_clk(8);
    cfg_request_n <= 1'b1;
    wait_clk(10);
    chk(err_oe_n, 1'b1);
    $display("restart test done");
  endtask
  task automatic brown_out(input logic act);
    supply_ok <= 1'b0;
    wait_clk(30);
    chk(err_oe_n, 1'b0);
    chk(err_out, 1'b0);
    chk(user_mode, 1'b0);
    chk(mem_oe_n, 1'b0);
    supply_ok <= 1'b1;
    wait_clk(40);
    chk(err_oe_n, act);
    $display("brown-out test done");
  endtask
  initial begin
    seed = 32'h2abb;
    core_clk = 1'b0;
    resetn = 1'b0;
    scheme_active = 1'b0;
    cfg_request_n = 1'b1;
    supply_ok = 1'b1;
    wait_clk(5);
    resetn <= 1'b1;
    wait_clk(10);
    load(-1);
    brown_out(1'b0);
    restart;
    load(2);
    restart;
    load(-1);
    resetn <= 1'b0;
    scheme_active <= 1'b1;
    wait_clk(5);
    resetn <= 1'b1;
    wait_clk(10);
    brown_out(1'b1);
    chk(clk_oe_n, 1'b0);
    chk_edges(16);
    summarize;
  end
  // Watchdog well past the longest expected run
  initial begin
    #300000;
    num_errors++;
    summarize;
  end
endmodule
